/* ulpi_tx_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - status bit 6 follows the ID pin
// - status bit 7 follows the alternate interrupt pin
// - status bits 0/1 follow DP and DM
// - mode decoded from speed, operation, pulldowns
// - packets bit-stuffed and NRZI coded, shared paths
// - high-speed packets start with 32-bit sync
// - full/low-speed packets start with 8-bit sync
// - chirp setting disables stuffing and NRZI
// - leftover chirp data goes out unstuffed
// - high-speed host appends 40-bit EOP after SOF
// - long EOP only with both pulldowns on
// - device sends normal EOP after SOF
// - low-speed SOF sends two-bit SE0 keep-alive
// - host sends full-speed preamble before low-speed packet
// - no preamble handling when pulldowns are off
// - host resume K ends with two-bit SE0
// - device resume K releases to idle, no SE0
// - automatic wake enable resets to zero
// - nxt throttles data; link holds bus meanwhile
module ulpi_tx_ctrl
  import ulpi_tx_pkg::*;
#(
  parameter int unsigned RESUME_K_CYCLES = RESUME_K_CYC
)(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // link side
  input  wire logic [7:0] txd_i,
  input  wire logic       stp_i,
  output logic            nxt_o,
  output logic      [7:0] rx_cmd_o,
  // low power control
  input  wire logic       low_power_i,
  input  wire logic       low_power_exit_i,
  // line pins
  input  wire logic       dp_i,
  input  wire logic       dm_i,
  input  wire logic       id_i,
  input  wire logic       alt_int_i,
  output logic            dp_o,
  output logic            dm_o,
  output logic            line_oe_b_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] bit_cycles(input rate_t r);
    case (r)
      RATE_HS: bit_cycles = 7'(HS_BIT_CYC);
      RATE_FS: bit_cycles = 7'(FS_BIT_CYC);
      default: bit_cycles = 7'(LS_BIT_CYC);
    endcase
  endfunction : bit_cycles

  // level 1 is J; low-speed J has the lines swapped
  function automatic line_t line_of(input logic lvl, input rate_t r);
    line_t j;
    j.dp = (r != RATE_LS);
    j.dm = (r == RATE_LS);
    line_of = lvl ? j : line_t'(~j);
  endfunction : line_of

  tx_regs_t s;
  tx_regs_t d;

  logic [1:0] speed;
  logic [1:0] op;
  logic       host;
  logic       auto_wake;
  logic       bit_en;
  logic       stuff_on;
  logic       capture;
  logic       tx_bit;
  logic       line_k;
  logic [7:0] src;
  logic [3:0] n_left;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign speed     = s.func[FUNC_SPEED_LSB +: 2];
  assign op        = s.func[FUNC_OP_LSB +: 2];
  assign host      = s.otg[OTG_DP_PD_BIT] & s.otg[OTG_DM_PD_BIT];
  assign auto_wake = s.ifc[IFC_AUTO_WAKE];
  assign bit_en    = (s.div == 7'h00);
  assign stuff_on  = !s.chirp;
  assign capture   = s.nxt && (s.st != ST_CMD);
  assign line_k    = !s.dp_s[1] && s.dm_s[1];

  always_comb
  begin
    d = s;
    tx_bit = 1'b0;
    src = s.shift;
    n_left = s.left;

    // pin synchronisers and receive command status
    d.dp_s  = {s.dp_s[0], dp_i};
    d.dm_s  = {s.dm_s[0], dm_i};
    d.id_s  = {s.id_s[0], id_i};
    d.alt_s = {s.alt_s[0], alt_int_i};
    d.rxcmd = 8'h00;
    d.rxcmd[0] = s.dp_s[1];
    d.rxcmd[1] = s.dm_s[1];
    d.rxcmd[RXCMD_ID_BIT]  = s.id_s[1];
    d.rxcmd[RXCMD_ALT_BIT] = s.alt_s[1];

    // -------------------------------------------------------------
    // register port
    // -------------------------------------------------------------
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        REG_FUNC: d.func = reg_wdata_i;
        REG_OTG:  d.otg  = reg_wdata_i;
        REG_IFC:  d.ifc  = reg_wdata_i;
        default:  d.func = s.func;
      endcase
    end
    d.rdata = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        REG_FUNC:   d.rdata = s.func;
        REG_OTG:    d.rdata = s.otg;
        REG_IFC:    d.rdata = s.ifc;
        REG_STATUS: d.rdata = {5'h00, s.st == ST_RES_K, s.stop,
                               s.st != ST_IDLE};
        REG_RXCMD:  d.rdata = s.rxcmd;
        default:    d.rdata = 8'h00;
      endcase
    end

    // bit-time divider, one enable pulse per bit
    d.div = bit_en ? bit_cycles(s.rate) - 7'h01 : s.div - 7'h01;

    // link data arrives only in a cycle with nxt high
    if (capture)
    begin
      if (stp_i)
        d.stop = 1'b1;
      else
      begin
        d.hold   = txd_i;
        d.hold_v = 1'b1;
      end
    end

    // -------------------------------------------------------------
    // transmit sequencer
    // -------------------------------------------------------------
    case (s.st)
      ST_IDLE:
      begin
        d.oe_b = 1'b1;
        d.ln   = line_of(1'b1, s.rate);
        d.rate = (speed == SPD_HS) ? RATE_HS :
                 (speed == SPD_FS) ? RATE_FS : RATE_LS;
        if (low_power_exit_i ||
            (auto_wake && host && low_power_i && line_k))
        begin
          d.st   = ST_RES_K;
          d.rate = RATE_FS;
          d.rcnt = 21'h000000;
        end
        else if (!low_power_i && op != OP_NODRIVE &&
                 txd_i[7:6] == TXCMD_CODE && txd_i[5:4] == 2'h0)
          d.st = ST_CMD;
      end

      ST_CMD:
      begin
        if (s.nxt)
        begin
          d.sof    = (txd_i[3:0] == SOF_PID);
          d.hold   = {~txd_i[3:0], txd_i[3:0]};
          d.hold_v = 1'b1;
          d.stop   = 1'b0;
          d.stuff  = 3'h0;
          d.left   = 4'h0;
          d.lvl    = 1'b1;
          d.chirp  = (op == OP_CHIRP);
          d.pre    = 1'b0;
          // first bit starts at once, so no stray J leads the sync
          d.div    = 7'h00;
          d.bcnt   = (s.rate == RATE_HS) ? SYNC_HS_BITS :
                     SYNC_FSLS_BITS;
          d.st     = ST_SYNC;
          if (op == OP_CHIRP)
            d.st = ST_DATA;
          else if (speed == SPD_LS && txd_i[3:0] == SOF_PID)
          begin
            d.hold_v = 1'b0;
            d.st     = ST_DRAIN;
          end
          else if (speed == SPD_LS_PRE && host)
          begin
            d.pre  = 1'b1;
            d.rate = RATE_FS;
          end
          // upstream hub port (no pulldowns) takes the plain path
        end
      end

      ST_SYNC:
      begin
        d.oe_b = 1'b0;
        if (bit_en)
        begin
          d.lvl  = (s.bcnt == 6'h01) ? s.lvl : !s.lvl;
          d.bcnt = s.bcnt - 6'h01;
          if (s.bcnt == 6'h01)
          begin
            d.stuff = 3'h1;
            if (s.pre)
            begin
              d.shift = PRE_PID_BYTE;
              d.left  = BYTE_BITS;
              d.st    = ST_PRE_PID;
            end
            else
              d.st = ST_DATA;
          end
        end
        d.ln = line_of(d.lvl, s.rate);
      end

      ST_PRE_PID:
      begin
        if (bit_en)
        begin
          tx_bit  = s.shift[0];
          d.shift = {1'b0, s.shift[7:1]};
          d.left  = s.left - 4'h1;
          d.lvl   = tx_bit ? s.lvl : !s.lvl;
          if (s.left == 4'h1)
          begin
            d.bcnt = PRE_IDLE_BITS;
            d.st   = ST_PRE_IDLE;
          end
        end
        d.ln = line_of(d.lvl, s.rate);
      end

      ST_PRE_IDLE:
      begin
        // full-speed idle, then the low-speed packet with its own sync
        d.ln = line_of(1'b1, RATE_FS);
        if (bit_en)
        begin
          d.bcnt = s.bcnt - 6'h01;
          if (s.bcnt == 6'h01)
          begin
            d.rate = RATE_LS;
            d.lvl  = 1'b1;
            d.pre  = 1'b0;
            d.bcnt = SYNC_FSLS_BITS;
            d.div  = bit_cycles(RATE_LS) - 7'h01;
            d.st   = ST_SYNC;
          end
        end
      end

      ST_DATA:
      begin
        d.oe_b = 1'b0;
        if (bit_en)
        begin
          if (stuff_on && s.stuff == STUFF_LIMIT)
          begin
            d.lvl   = !s.lvl;
            d.stuff = 3'h0;
          end
          else if (s.left != 4'h0 || s.hold_v)
          begin
            if (s.left == 4'h0)
            begin
              src    = s.hold;
              n_left = BYTE_BITS;
              d.hold_v = capture && !stp_i;
            end
            tx_bit  = src[0];
            d.shift = {1'b0, src[7:1]};
            d.left  = n_left - 4'h1;
            d.stuff = tx_bit ? s.stuff + 3'h1 : 3'h0;
            // chirp drives the raw bit, otherwise NRZI
            d.lvl   = s.chirp ? tx_bit : (tx_bit ? s.lvl : !s.lvl);
          end
          else if (s.stop)
          begin
            if (s.chirp)
              d.st = ST_IDLE;   // leftover data not guarded
            else if (s.rate == RATE_HS)
            begin
              // first EOP bit is a forced transition
              d.lvl  = !s.lvl;
              d.bcnt = (s.sof && host) ? EOP_LONG_BITS - 6'h01 :
                       EOP_HS_BITS - 6'h01;
              d.st   = ST_EOP;
            end
            else
            begin
              d.bcnt = SE0_BITS;
              d.st   = ST_EOP;
            end
          end
        end
        d.ln = line_of(d.lvl, s.rate);
      end

      ST_DRAIN:
      begin
        // frame bytes are fetched and dropped; the line stays idle
        d.hold_v = 1'b0;
        if (s.stop)
        begin
          d.oe_b = 1'b0;
          d.bcnt = SE0_BITS;
          d.div  = bit_cycles(RATE_LS) - 7'h01;
          d.st   = ST_EOP;
        end
      end

      ST_EOP:
      begin
        d.oe_b = 1'b0;
        if (s.rate == RATE_HS)
          d.ln = line_of(s.lvl, s.rate);
        else
          d.ln = '0;
        if (bit_en)
        begin
          d.bcnt = s.bcnt - 6'h01;
          if (s.bcnt == 6'h01)
          begin
            d.bcnt = 6'h01;
            d.st   = (s.rate == RATE_HS) ? ST_IDLE : ST_EOP_J;
          end
        end
      end

      ST_EOP_J:
      begin
        d.ln = line_of(1'b1, s.rate);
        if (bit_en)
          d.st = ST_IDLE;
      end

      ST_RES_K:
      begin
        d.oe_b = 1'b0;
        d.ln   = line_of(1'b0, RATE_FS);
        d.rcnt = s.rcnt + 21'h000001;
        if (s.rcnt >= 21'(RESUME_K_CYCLES - 1))
        begin
          if (host)
          begin
            d.rate = RATE_LS;
            d.bcnt = SE0_BITS;
            d.div  = bit_cycles(RATE_LS) - 7'h01;
            d.st   = ST_EOP;
          end
          else
          begin
            d.oe_b = 1'b1;
            d.st   = ST_IDLE;
          end
        end
      end

      default:
        d.st = ST_IDLE;
    endcase

    // nxt asks for one byte when the holding slot is free and nxt was low the cycle before
    d.nxt = (d.st == ST_CMD && s.st == ST_IDLE) ||
            ((d.st == ST_SYNC || d.st == ST_DATA || d.st == ST_DRAIN ||
              d.st == ST_PRE_PID || d.st == ST_PRE_IDLE) &&
             !d.stop && !d.hold_v && !s.nxt);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s      <= '0;
      s.st   <= ST_IDLE;
      s.rate <= RATE_FS;
      s.oe_b <= 1'b1;
      s.ln   <= line_t'(2'h2);
      s.lvl  <= 1'b1;
      s.func <= FUNC_RST;
      s.otg  <= OTG_RST;
      s.ifc  <= IFC_RST;
    end
    else
      s <= d;
  end

  assign reg_rdata_o = s.rdata;
  assign nxt_o       = s.nxt;
  assign rx_cmd_o    = s.rxcmd;
  assign dp_o        = s.ln.dp;
  assign dm_o        = s.ln.dm;
  assign line_oe_b_o = s.oe_b;

endmodule : ulpi_tx_ctrl

/* ulpi_tx_pkg.sv */
package ulpi_tx_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int HS_BIT_PS     = 2083;
  localparam int FS_BIT_PS     = 83333;
  localparam int LS_BIT_PS     = 666667;
  // nominal bit periods round down, never below one cycle
  localparam int HS_BIT_CYC = (HS_BIT_PS / CLK_PERIOD_PS < 1) ? 1 :
                              HS_BIT_PS / CLK_PERIOD_PS;
  localparam int FS_BIT_CYC = (FS_BIT_PS / CLK_PERIOD_PS < 1) ? 1 :
                              FS_BIT_PS / CLK_PERIOD_PS;
  localparam int LS_BIT_CYC = (LS_BIT_PS / CLK_PERIOD_PS < 1) ? 1 :
                              LS_BIT_PS / CLK_PERIOD_PS;
  localparam int RESUME_K_US  = 20000;
  localparam int RESUME_K_CYC = RESUME_K_US * 1000000 / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // bit counts
  // ---------------------------------------------------------------
  localparam logic [5:0] SYNC_HS_BITS   = 6'd32;
  localparam logic [5:0] SYNC_FSLS_BITS = 6'd8;
  localparam logic [5:0] EOP_HS_BITS    = 6'd8;
  localparam logic [5:0] EOP_LONG_BITS  = 6'd40;
  localparam logic [5:0] SE0_BITS       = 6'd2;
  localparam logic [5:0] PRE_IDLE_BITS  = 6'd4;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [2:0] STUFF_LIMIT    = 3'h6;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] TXCMD_CODE   = 2'h1;
  localparam logic [3:0] SOF_PID      = 4'h5;
  localparam logic [7:0] PRE_PID_BYTE = 8'hC3;
  localparam logic [1:0] SPD_HS       = 2'h0;
  localparam logic [1:0] SPD_FS       = 2'h1;
  localparam logic [1:0] SPD_LS       = 2'h2;
  localparam logic [1:0] SPD_LS_PRE   = 2'h3;
  localparam logic [1:0] OP_NODRIVE   = 2'h1;
  localparam logic [1:0] OP_CHIRP     = 2'h2;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_FUNC   = 4'h0;
  localparam logic [3:0] REG_OTG    = 4'h1;
  localparam logic [3:0] REG_IFC    = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RXCMD  = 4'h4;
  localparam int FUNC_SPEED_LSB  = 0;
  localparam int FUNC_TERM_BIT   = 2;
  localparam int FUNC_OP_LSB     = 3;
  localparam int OTG_DP_PD_BIT   = 1;
  localparam int OTG_DM_PD_BIT   = 2;
  localparam int IFC_AUTO_WAKE   = 4;
  localparam int RXCMD_ID_BIT    = 6;
  localparam int RXCMD_ALT_BIT   = 7;
  localparam logic [7:0] FUNC_RST = 8'h05;
  localparam logic [7:0] OTG_RST  = 8'h06;
  localparam logic [7:0] IFC_RST  = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_SYNC, ST_PRE_PID, ST_PRE_IDLE, ST_DATA,
    ST_DRAIN, ST_EOP, ST_EOP_J, ST_RES_K
  } tx_state_t;

  typedef enum logic [1:0] {RATE_HS, RATE_FS, RATE_LS} rate_t;

  typedef struct packed {
    logic dp;
    logic dm;
  } line_t;

  typedef struct packed {
    tx_state_t   st;
    rate_t       rate;
    logic [6:0]  div;
    logic [5:0]  bcnt;
    logic [7:0]  shift;
    logic [3:0]  left;
    logic [7:0]  hold;
    logic        hold_v;
    logic        stop;
    logic [2:0]  stuff;
    logic        lvl;
    logic        sof;
    logic        pre;
    logic        chirp;
    logic        nxt;
    logic        oe_b;
    line_t       ln;
    logic [7:0]  rxcmd;
    logic [7:0]  rdata;
    logic [1:0]  dp_s;
    logic [1:0]  dm_s;
    logic [1:0]  id_s;
    logic [1:0]  alt_s;
    logic [7:0]  func;
    logic [7:0]  otg;
    logic [7:0]  ifc;
    logic [20:0] rcnt;
  } tx_regs_t;

endpackage : ulpi_tx_pkg

/* ulpi_link_model.sv */
`timescale 1ns/10ps
module ulpi_link_model
(
  // link side
  input  wire logic       core_clk_i,
  input  wire logic       nxt_i,
  output logic      [7:0] txd_o,
  output logic            stp_o
);
  initial
  begin
    txd_o = 8'h00;
    stp_o = 1'b0;
  end

  task automatic wait_nxt();
    int k;
    k = 0;
    do
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (nxt_i !== 1'b1 && k < 2000);
  endtask : wait_nxt

  // gap lets the link answer late; bytes are held until the phy takes them
  task automatic send(input logic [3:0] pid, input int n,
                      input logic [7:0] b, input int gap);
    repeat (gap) @(posedge core_clk_i);
    txd_o <= {4'h4, pid};
    wait_nxt();
    for (int i = 0; i < n; i++)
    begin
      txd_o <= b;
      wait_nxt();
    end
    stp_o <= 1'b1;
    wait_nxt();
    stp_o <= 1'b0;
    txd_o <= 8'h00;
  endtask : send
endmodule : ulpi_link_model

/* ulpi_tx_ctrl_chk.sv */
`timescale 1ns/10ps
module ulpi_tx_ctrl_chk
  import ulpi_tx_pkg::*;
(
  // watched ports
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] txd_i,
  input wire logic       nxt_o,
  input wire logic [7:0] rx_cmd_o,
  input wire logic       low_power_i,
  input wire logic       low_power_exit_i,
  input wire logic       dp_i,
  input wire logic       dm_i,
  input wire logic       id_i,
  input wire logic       alt_int_i,
  input wire logic       dp_o,
  input wire logic       dm_o,
  input wire logic       line_oe_b_o
);
  // pins need a few cycles through the synchronisers after reset
  logic [2:0] up_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence wake_req;
    low_power_i && low_power_exit_i;
  endsequence
  sequence k_on_line;
    !line_oe_b_o && !dp_o && dm_o;
  endsequence

  chk_id_bit: assert property (up_q == 3'h7 && $stable(id_i)[*4]
    |-> rx_cmd_o[6] == id_i) else $error("id status bit wrong");
  chk_alt_bit: assert property (up_q == 3'h7 && $stable(alt_int_i)[*4]
    |-> rx_cmd_o[7] == alt_int_i) else $error("alt status bit wrong");
  chk_line_bits: assert property (up_q == 3'h7 && $stable({dp_i, dm_i})[*4]
    |-> rx_cmd_o[1:0] == {dm_i, dp_i}) else $error("line bits wrong");
  chk_rdata_zero: assert property (!$past(reg_rd_i)
    |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
  chk_nxt_pulse: assert property (nxt_o |=> !nxt_o)
    else $error("nxt held two cycles");
  chk_lp_refuse: assert property (low_power_i[*2] |-> !nxt_o)
    else $error("byte taken in low power");
  chk_resume_k: assert property (wake_req |-> ##[1:3] k_on_line)
    else $error("no resume k");
  chk_release_j: assert property ($rose(line_oe_b_o)
    |-> $past(dp_o) != $past(dm_o)) else $error("release from se0");
  chk_cmd_take: assert property (line_oe_b_o && !nxt_o && !low_power_i
    && txd_i[7:4] == 4'h4 |=> nxt_o) else $error("command not taken");
endmodule : ulpi_tx_ctrl_chk

bind ulpi_tx_ctrl ulpi_tx_ctrl_chk u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .txd_i(txd_i), .nxt_o(nxt_o),
  .rx_cmd_o(rx_cmd_o), .low_power_i(low_power_i),
  .low_power_exit_i(low_power_exit_i), .dp_i(dp_i), .dm_i(dm_i),
  .id_i(id_i), .alt_int_i(alt_int_i), .dp_o(dp_o), .dm_o(dm_o),
  .line_oe_b_o(line_oe_b_o)
);

/* ulpi_tx_ctrl_tb.sv */
`timescale 1ns/10ps
module ulpi_tx_ctrl_tb
  import ulpi_tx_pkg::*;
;
  logic        core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, stp_i, nxt_o;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, txd_i, rx_cmd_o, rd_v;
  logic        low_power_i, low_power_exit_i, dp_i, dm_i, id_i, alt_int_i;
  logic        dp_o, dm_o, line_oe_b_o;
  logic [15:0] low_n, se0_n, last_len, last_se0, l1;
  int          num_errors, checks, cyc;
  logic        s [0:79];
  logic [3:0]  adr [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
  logic [7:0]  dfl [4] = '{8'h05, 8'h06, 8'h00, 8'h00};

  ulpi_tx_ctrl #(.RESUME_K_CYCLES(20)) u_ulpi_tx_ctrl (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .txd_i(txd_i), .stp_i(stp_i), .nxt_o(nxt_o),
    .rx_cmd_o(rx_cmd_o), .low_power_i(low_power_i),
    .low_power_exit_i(low_power_exit_i), .dp_i(dp_i), .dm_i(dm_i),
    .id_i(id_i), .alt_int_i(alt_int_i), .dp_o(dp_o), .dm_o(dm_o),
    .line_oe_b_o(line_oe_b_o));
  ulpi_link_model u_link (.core_clk_i(core_clk_i), .nxt_i(nxt_o),
    .txd_o(txd_i), .stp_o(stp_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ------
  // line monitor: drive time and se0 run lengths
  // ------
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      end_of_test();
    end
    if (line_oe_b_o === 1'b0)
    begin
      low_n <= low_n + 16'h1;
      if ({dp_o, dm_o} === 2'b00)
        se0_n <= se0_n + 16'h1;
      else if (se0_n != 16'h0)
      begin
        last_se0 <= se0_n;
        se0_n <= 16'h0;
      end
    end
    else if (low_n != 16'h0)
    begin
      last_len <= low_n;
      low_n <= 16'h0;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic wait_idle();
    int k;
    k = 0;
    while (line_oe_b_o !== 1'b0 && k < 300)
    begin
      @(posedge core_clk_i);
      k++;
    end
    while (line_oe_b_o !== 1'b1 && k < 5000)
    begin
      @(posedge core_clk_i);
      k++;
    end
    @(posedge core_clk_i);
  endtask : wait_idle

  // samples dp once per bit from the first driven cycle
  task automatic capture(input int n, input int bc);
    int k;
    k = 0;
    while (line_oe_b_o !== 1'b0 && k < 300)
    begin
      @(posedge core_clk_i);
      k++;
    end
    repeat (bc / 2) @(posedge core_clk_i);
    for (int i = 0; i < n; i++)
    begin
      s[i] = dp_o;
      repeat (bc) @(posedge core_clk_i);
    end
  endtask : capture

  task automatic xfer(input logic [3:0] pid, input int n, input logic [7:0] b,
                      input int bc, input int ns);
    last_se0 = 16'h0;
    fork
      u_link.send(pid, n, b, 1);
      capture(ns, bc);
    join
    wait_idle();
  endtask : xfer

  task automatic wake(input logic [7:0] otg, input logic [15:0] se0);
    wr(REG_OTG, otg);
    low_power_i <= 1'b1;
    @(posedge core_clk_i);
    low_power_exit_i <= 1'b1;
    @(posedge core_clk_i);
    low_power_exit_i <= 1'b0;
    last_se0 = 16'h0;
    wait_idle();
    low_power_i <= 1'b0;
    chk(last_se0, se0);
  endtask : wake

  function automatic int sync_len();
    int i;
    i = 1;
    while (i < 79 && s[i] !== s[i-1])
      i++;
    return i + 1;
  endfunction : sync_len

  function automatic int run_max(input int lo);
    int r, m;
    r = 1;
    m = 1;
    for (int i = lo + 1; i < 80; i++)
    begin
      r = (s[i] === s[i-1]) ? r + 1 : 1;
      m = (r > m) ? r : m;
    end
    return m;
  endfunction : run_max

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial
  begin
    {rst_b_i, reg_wr_i, reg_rd_i, low_power_i, low_power_exit_i} = 5'h0;
    {reg_addr_i, reg_wdata_i, dp_i, dm_i, id_i, alt_int_i} = 16'h000D;
    {low_n, se0_n, last_len, last_se0} = 64'h0;
    {num_errors, checks, cyc} = 96'h0;
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 4; i++)
    begin
      rd(adr[i], rd_v);
      chk(rd_v, dfl[i]);
    end
    wr(REG_IFC, 8'h10);
    wr(4'hF, 8'hFF);
    rd(REG_IFC, rd_v);
    chk(rd_v, 8'h10);
    for (int i = 0; i < 16; i++)
    begin
      {alt_int_i, id_i, dm_i, dp_i} <= i[3:0];
      repeat (4) @(posedge core_clk_i);
      chk(rx_cmd_o, {i[3], i[2], 4'h0, i[1], i[0]});
    end
    {alt_int_i, id_i, dm_i, dp_i} <= 4'h5;
    for (int k = 0; k < 2; k++)
    begin
      wr(REG_FUNC, k ? 8'h06 : 8'h05);
      xfer(4'h1, 1, 8'h5A, k ? LS_BIT_CYC : FS_BIT_CYC, 10);
      chk(sync_len(), 8);
      chk(last_se0, 2 * (k ? LS_BIT_CYC : FS_BIT_CYC));
    end
    wr(REG_FUNC, 8'h00);
    xfer(4'h1, 4, 8'hFF, 1, 80);
    chk(sync_len(), 32);
    chk(run_max(40), 7);
    wr(REG_FUNC, 8'h10);
    xfer(4'h0, 2, 8'h00, 1, 8);
    chk(sync_len(), 2);
    wr(REG_FUNC, 8'h00);
    xfer(SOF_PID, 2, 8'h3C, 1, 1);
    l1 = last_len;
    wr(REG_OTG, 8'h00);
    xfer(SOF_PID, 2, 8'h3C, 1, 1);
    chk(l1 - last_len, 16'd32);
    wr(REG_OTG, 8'h06);
    wr(REG_FUNC, 8'h06);
    xfer(SOF_PID, 0, 8'h00, LS_BIT_CYC, 1);
    chk(last_se0, 2 * LS_BIT_CYC);
    chk(last_len < 16'd528, 1'b1);
    wr(REG_FUNC, 8'h07);
    xfer(4'h1, 1, 8'h5A, FS_BIT_CYC, 10);
    chk(sync_len(), 8);
    wr(REG_OTG, 8'h00);
    xfer(4'h1, 1, 8'h5A, FS_BIT_CYC, 10);
    chk(sync_len() == 8, 1'b0);
    wr(REG_FUNC, 8'h05);
    wake(8'h06, 2 * LS_BIT_CYC);
    wake(8'h00, 16'h0);
    end_of_test();
  end
endmodule : ulpi_tx_ctrl_tb
